// ===== uart_line_status_modem_ctrl_bench.sv
// self-checking bench for the line status and handshake control logic
// assumes the design files and ulm_far_end are compiled first
`timescale 1ns/1ns
`include "ulm_params.svh"

module uart_line_status_modem_ctrl_bench import ulm_pkg::*;;
   localparam int BC = 4; // short bit time keeps the run brief
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   localparam logic [7:0] A_LS = `ULM_OFF_LSTAT;
   localparam logic [7:0] A_HC = `ULM_OFF_HCTL;
   localparam logic [7:0] A_HS = `ULM_OFF_HSTAT;
   localparam logic [7:0] A_DT = `ULM_OFF_DATA;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
   logic [7:0] paddr, ch;
   logic [31:0] pwdata, prdata, rd;
   logic serial_tx_pin, serial_rx_pin, rts_n, dtr_n, irq_out, lo;
   ulm_modem_t modem_in;
   int err_count, n_compared;

   ulm_uart #(.DEPTH(4), .BIT_CYC(BC)) i_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_tx_pin(serial_tx_pin),
      .serial_rx_pin(serial_rx_pin), .rts_n(rts_n), .dtr_n(dtr_n),
      .modem_in(modem_in), .irq_out(irq_out));
   ulm_far_end #(.BC(BC)) i_far (.pclk(pclk), .serial_tx_pin(serial_tx_pin),
      .serial_rx_pin(serial_rx_pin), .modem_in(modem_in));

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (err_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // masked value compare
   task automatic chk(input logic [31:0] got, e, m, input string s);
      n_compared++;
      if ((got & m) !== e) begin
         err_count++;
         $display("wrong value at %0t: %s got %h", $time, s, got);
      end
   endtask

   // apb transfer: setup, access until pready, then one idle edge
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         report_and_stop();
      end
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h000000, d});
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, m);
      bus(1'b0, a, 32'h00000000);
      chk(rd, e, m, "register read");
   endtask

   task automatic pins(input logic [31:0] e);
      chk({30'h0, rts_n, dtr_n}, e, ALL, "modem outputs");
   endtask

   task automatic irq(input logic [31:0] e);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq_out}, e, ALL, "interrupt");
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rc(A_LS, 32'h60, ALL);
      rc(A_HC, 32'h00, ALL);
      pins(32'h3);
      bus(1'b0, 8'h1C, 32'h0);
      chk({31'h0, slverr}, 32'h1, ALL, "unmapped error");
   endtask

   task automatic t_hctl();
      wr(A_HC, 8'hE2);
      rc(A_HC, 32'h02, ALL);
      pins(32'h1);
      wr(A_HC, 8'h05);
      pins(32'h2);
      // pin levels differ from every control bit, so a stray mux shows
      i_far.set_pins(4'b0110);
      repeat (4) @(posedge pclk);
      rc(A_HS, 32'h90, ALL);
      wr(A_HC, 8'h17);
      rc(A_HS, 32'h70, ALL);
      pins(32'h3);
      wr(A_HC, 8'h18);
      rc(A_HS, 32'h80, ALL);
   endtask

   task automatic t_irq();
      wr(A_HC, 8'h08);
      irq(32'h0);
      wr(`ULM_OFF_IRQEN, 8'h02);
      irq(32'h1);
      wr(A_HC, 8'h00);
      irq(32'h0);
   endtask

   // two back-to-back characters: second waits in the holding stage
   task automatic t_tx();
      fork
         begin
            i_far.grab(ch);
            chk({24'h0, ch}, 32'hA5, ALL, "tx char");
            i_far.grab(ch);
            chk({24'h0, ch}, 32'h3C, ALL, "tx char");
         end
         begin
            wr(A_DT, 8'hA5);
            repeat (BC) @(posedge pclk);
            wr(A_DT, 8'h3C);
            rc(A_LS, 32'h00, 32'h60);
         end
      join
      repeat (3 * BC) @(posedge pclk);
      rc(A_LS, 32'h60, ALL);
   endtask

   // single-buffer receive with even parity
   task automatic t_rx();
      wr(`ULM_OFF_LINE, 8'h03);
      i_far.send(8'h3C, 1'b0, 1'b1);
      rc(A_LS, 32'h61, ALL);
      rc(A_DT, 32'h3C, ALL);
      rc(A_LS, 32'h60, ALL);
      i_far.send(8'h5A, 1'b1, 1'b1);
      rc(A_LS, 32'h65, ALL);
      rc(A_LS, 32'h61, ALL);
      rc(A_DT, 32'h5A, ALL);
      i_far.send(8'h81, 1'b0, 1'b0);
      rc(A_LS, 32'h69, ALL);
      rc(A_DT, 32'h81, ALL);
      i_far.send(8'h00, 1'b0, 1'b0);
      rc(A_LS, 32'h19, 32'h1F);
      rc(A_DT, 32'h00, ALL);
      i_far.send(8'h11, 1'b0, 1'b1);
      i_far.send(8'h22, 1'b0, 1'b1);
      rc(A_LS, 32'h63, ALL);
      rc(A_DT, 32'h22, ALL);
      rc(A_LS, 32'h60, ALL);
   endtask

   // fifo mode: errored character ahead of a clean one
   task automatic t_fifo();
      wr(`ULM_OFF_FIFO, 8'h01);
      rc(`ULM_OFF_FIFO, 32'h01, 32'h01);
      i_far.send(8'h5A, 1'b1, 1'b1);
      i_far.send(8'h3C, 1'b0, 1'b1);
      rc(A_LS, 32'h85, 32'h85);
      rc(A_LS, 32'h80, 32'h80);
      rc(A_DT, 32'h5A, ALL);
      rc(A_LS, 32'h01, 32'h05);
      rc(A_LS, 32'h01, 32'h81);
      rc(A_DT, 32'h3C, ALL);
      wr(`ULM_OFF_FIFO, 8'h00);
   endtask

   // loopback: pin frame ignored, transmit line held high
   task automatic t_loop();
      wr(A_HC, 8'h10);
      i_far.send(8'h00, 1'b0, 1'b0);
      rc(A_LS, 32'h60, ALL);
      wr(A_DT, 8'hC3);
      lo = 1'b0;
      repeat (14 * BC) begin
         @(posedge pclk);
         lo = lo | (serial_tx_pin !== 1'b1);
      end
      chk({31'h0, lo}, 32'h0, ALL, "tx pin low");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      err_count = 0;
      n_compared = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_hctl();
      t_irq();
      t_tx();
      t_rx();
      t_fifo();
      t_loop();
      report_and_stop();
   end
endmodule

// ===== ulm_far_end.sv
// far-end serial device and modem handshake pins for the bench
// assumes every line changes just after a rising pclk edge
`timescale 1ns/1ns

module ulm_far_end import ulm_pkg::*; #(
   parameter int BC = 4 // clocks per serial bit
)(
   input wire logic pclk,
   input wire logic serial_tx_pin,
   output logic serial_rx_pin,
   output ulm_modem_t modem_in
);
   // idle line high, handshake inputs inactive
   initial begin
      serial_rx_pin = 1'b1;
      modem_in = 4'hF;
   end

   ////////////////////////////////////////////////////////////////////////
   // one frame: start, data, parity, stop; then idle so flags can land
   task automatic send(input logic [7:0] d, input logic pb, input logic sb);
      logic [10:0] fr;
      fr = {sb, pb, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         serial_rx_pin <= fr[i];
         repeat (BC) @(posedge pclk);
      end
      serial_rx_pin <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask

   // sample one character mid-bit; zero if the line never starts
   task automatic grab(output logic [7:0] d);
      int w;
      d = 8'h00;
      for (w = 0; w < 400 && serial_tx_pin !== 1'b0; w++) @(posedge pclk);
      if (serial_tx_pin === 1'b0) begin
         repeat (BC / 2) @(posedge pclk);
         for (int i = 0; i < 8; i++) begin
            repeat (BC) @(posedge pclk);
            d[i] = serial_tx_pin;
         end
      end
   endtask

   // handshake inputs are plain levels
   task automatic set_pins(input ulm_modem_t m);
      modem_in <= m;
   endtask
endmodule

// ===== ulm_params.svh
// offsets, field positions, reset values and timing for the serial port
// assumes a 32-bit apb slave with byte addresses, one register per word
`ifndef ULM_PARAMS_SVH
`define ULM_PARAMS_SVH

// register byte offsets
`define ULM_OFF_DATA 8'h00
`define ULM_OFF_IRQEN 8'h04
`define ULM_OFF_FIFO 8'h08
`define ULM_OFF_LINE 8'h0C
`define ULM_OFF_HCTL 8'h10
`define ULM_OFF_LSTAT 8'h14
`define ULM_OFF_HSTAT 8'h18

// line status bit positions
`define ULM_LS_RDY 0
`define ULM_LS_OVR 1
`define ULM_LS_PAR 2
`define ULM_LS_SIL 4
`define ULM_LS_THE 5
`define ULM_LS_TAE 6
`define ULM_LS_RFE 7

// handshake control bit positions
`define ULM_HC_DTR 0
`define ULM_HC_RTS 1
`define ULM_HC_RIL 2
`define ULM_HC_IRQ 3
`define ULM_HC_LOOP 4

// fifo control, line config and irq enable bit positions
`define ULM_FC_EN 0
`define ULM_FC_RXRST 1
`define ULM_FC_TXRST 2
`define ULM_LC_PEN 0
`define ULM_LC_EVEN 1
`define ULM_IE_TXE 1

// reset values
`define ULM_HC_RST 5'h00
`define ULM_LC_RST 2'h0

// timing: clock period and bit time in ns
`define ULM_CLK_NS 100
`define ULM_BIT_NS 1000
`define ULM_BIT_CYC (`ULM_BIT_NS / `ULM_CLK_NS)

`endif

// ===== ulm_pkg.sv
// types shared by the serial port line status and modem control logic
// assumes ulm_params.svh supplies the numbers
package ulm_pkg;

   // one received character with its three error marks
   typedef struct packed {
      logic sil;         // whole frame low
      logic nstp;        // stop bit low
      logic perr;        // parity mismatch
      logic [7:0] dat;   // data, bit 0 first on the line
   } ulm_rx_ent_t;

   // active-low modem inputs grouped together
   typedef struct packed {
      logic dcd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } ulm_modem_t;

   // serial engine states, shared by transmitter and receiver
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_DATA = 3'b010,
      ST_PAR = 3'b011,
      ST_STOP = 3'b100,
      ST_HOLD = 3'b101
   } ulm_st_t;

endpackage

// ===== ulm_uart.sv
// serial port with line status and handshake control behind apb
// assumes apb master on pclk, serial and modem pins synchronous to pclk
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "ulm_params.svh"

module ulm_uart import ulm_pkg::*; #(
   parameter int DEPTH = 16,            // fifo depth, power of two
   parameter int BIT_CYC = `ULM_BIT_CYC // clocks per serial bit
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic serial_tx_pin,
   input wire logic serial_rx_pin,
   output logic rts_n,
   output logic dtr_n,
   input wire ulm_modem_t modem_in,
   output logic irq_out
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULLN = (AW+1)'(DEPTH);
   localparam logic [15:0] BITN = 16'(BIT_CYC - 1);
   localparam logic [15:0] HALFN = 16'(BIT_CYC / 2);

   ////////////////////////////////////////////////////////////////////
   // apb decode

   // true for any address the slave answers
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         `ULM_OFF_DATA, `ULM_OFF_IRQEN, `ULM_OFF_FIFO, `ULM_OFF_LINE,
         `ULM_OFF_HCTL, `ULM_OFF_LSTAT, `ULM_OFF_HSTAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // any error mark set in a character
   function automatic logic ent_err(input ulm_rx_ent_t e);
      ent_err = e.sil | e.nstp | e.perr;
   endfunction

   logic acc;        // access phase, zero wait states
   logic wr;         // write takes effect this edge
   logic rd;         // read completes this edge
   assign acc = psel & penable;
   assign wr = acc & pwrite & mapped(paddr);
   assign rd = acc & ~pwrite & mapped(paddr);
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped(paddr);

   logic data_wr, data_rd, st_rd, fifo_wr;
   assign data_wr = wr & (paddr == `ULM_OFF_DATA);
   assign data_rd = rd & (paddr == `ULM_OFF_DATA);
   assign st_rd = rd & (paddr == `ULM_OFF_LSTAT);
   assign fifo_wr = wr & (paddr == `ULM_OFF_FIFO);

   ////////////////////////////////////////////////////////////////////
   // control registers

   logic [4:0] hctl_reg;  // handshake control, bits 7..5 not stored
   logic fen_reg;         // fifo mode
   logic [1:0] lcfg_reg;  // parity enable, even parity
   logic txie_reg;        // tx holding empty irq enable

   // software writes; reserved bits dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hctl_reg <= `ULM_HC_RST;
         fen_reg <= 1'b0;
         lcfg_reg <= `ULM_LC_RST;
         txie_reg <= 1'b0;
      end else if (wr) begin
         case (paddr)
            `ULM_OFF_HCTL: hctl_reg <= pwdata[4:0];
            `ULM_OFF_FIFO: fen_reg <= pwdata[`ULM_FC_EN];
            `ULM_OFF_LINE: lcfg_reg <= pwdata[1:0];
            `ULM_OFF_IRQEN: txie_reg <= pwdata[`ULM_IE_TXE];
            default: ;
         endcase
      end
   end

   logic loop;
   assign loop = hctl_reg[`ULM_HC_LOOP];

   // a mode change empties both fifos, so depth never shrinks under data
   logic rx_rst, tx_rst, mode_chg;
   assign mode_chg = fifo_wr & (pwdata[`ULM_FC_EN] != fen_reg);
   assign rx_rst = fifo_wr & pwdata[`ULM_FC_RXRST] | mode_chg;
   assign tx_rst = fifo_wr & pwdata[`ULM_FC_TXRST] | mode_chg;

   logic [AW:0] cap;   // one slot in single-buffer mode
   assign cap = fen_reg ? FULLN : {{AW{1'b0}}, 1'b1};

   ////////////////////////////////////////////////////////////////////
   // modem pins and loopback

   logic tx_line;       // shifter output before the loopback mux
   logic rx_in;         // receiver input after the loopback mux
   logic [3:0] mstat;   // dcd, ri, dsr, cts as status levels

   assign serial_tx_pin = loop ? 1'b1 : tx_line;
   assign rx_in = loop ? tx_line : serial_rx_pin;
   assign rts_n = loop ? 1'b1 : ~hctl_reg[`ULM_HC_RTS];
   assign dtr_n = loop ? 1'b1 : ~hctl_reg[`ULM_HC_DTR];
   // ring bit only reaches status here, in loopback
   assign mstat = loop ? {hctl_reg[`ULM_HC_IRQ], hctl_reg[`ULM_HC_RIL],
                          hctl_reg[`ULM_HC_DTR], hctl_reg[`ULM_HC_RTS]}
                       : ~modem_in;

   ////////////////////////////////////////////////////////////////////
   // transmit fifo and shifter

   logic [7:0] tx_mem [DEPTH];
   logic [AW-1:0] tx_wp, tx_rp;
   logic [AW:0] tx_cnt;
   logic [15:0] tx_div;
   logic tx_tick, tx_push, tx_pop;
   ulm_st_t tx_st;
   logic [7:0] tx_byte;
   logic [2:0] tx_bit;
   logic hold_empty_reg;   // transmit holding stage empty

   assign tx_tick = (tx_div == 16'h0000);
   assign tx_push = data_wr & (tx_cnt < cap); // full fifo drops the write
   assign tx_pop = tx_tick & (tx_st == ST_IDLE) & (tx_cnt != '0);

   // bit-rate enable divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tx_div <= 16'h0000;
      else
         tx_div <= tx_tick ? BITN : tx_div - 16'h0001;
   end

   // fifo storage
   always_ff @(posedge pclk) begin
      if (tx_push)
         tx_mem[tx_wp] <= pwdata[7:0];
   end

   // fifo pointers and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_cnt <= '0;
      end else if (tx_rst) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_cnt <= '0;
      end else begin
         if (tx_push)
            tx_wp <= tx_wp + 1'b1;
         if (tx_pop)
            tx_rp <= tx_rp + 1'b1;
         tx_cnt <= tx_cnt + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
      end
   end

   // one state per bit period, moved on the bit-rate enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st <= ST_IDLE;
         tx_line <= 1'b1;
         tx_byte <= 8'h00;
         tx_bit <= 3'h0;
      end else if (tx_tick) begin
         case (tx_st)
            ST_IDLE: if (tx_pop) begin
               tx_byte <= tx_mem[tx_rp];
               tx_line <= 1'b0;
               tx_st <= ST_START;
            end
            ST_START: begin
               tx_line <= tx_byte[0];
               tx_bit <= 3'h0;
               tx_st <= ST_DATA;
            end
            ST_DATA: if (tx_bit == 3'h7) begin
               tx_line <= lcfg_reg[`ULM_LC_PEN] ?
                  (^tx_byte ^ ~lcfg_reg[`ULM_LC_EVEN]) : 1'b1;
               tx_st <= lcfg_reg[`ULM_LC_PEN] ? ST_PAR : ST_STOP;
            end else begin
               tx_line <= tx_byte[tx_bit + 3'h1];
               tx_bit <= tx_bit + 3'h1;
            end
            ST_PAR: begin
               tx_line <= 1'b1;
               tx_st <= ST_STOP;
            end
            ST_STOP: tx_st <= ST_IDLE;
            default: tx_st <= ST_IDLE;
         endcase
      end
   end

   // holding empty: set on last move to shifter, cleared by data write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hold_empty_reg <= 1'b1;
      else if (tx_rst || (tx_pop && tx_cnt == 1 && !tx_push))
         hold_empty_reg <= 1'b1;
      else if (tx_push)
         hold_empty_reg <= 1'b0;
   end

   logic temt;
   assign temt = (tx_cnt == '0) & (tx_st == ST_IDLE);

   // interrupt request, gated by the control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_out <= 1'b0;
      else
         irq_out <= hctl_reg[`ULM_HC_IRQ] & txie_reg
                    & hold_empty_reg;
   end

   ////////////////////////////////////////////////////////////////////
   // receiver

   ulm_st_t rx_st;
   logic [15:0] rx_tmr;
   logic [7:0] rx_sh;
   logic [2:0] rx_bit;
   logic rx_zero, rx_pbit, rx_done;
   ulm_rx_ent_t rx_ent;

   assign rx_done = (rx_st == ST_STOP) & (rx_tmr == 16'h0000);
   // one driver for the whole entry: silent, missing stop, parity, data
   assign rx_ent = {rx_zero & ~rx_in,
                    ~rx_in,
                    lcfg_reg[`ULM_LC_PEN] &
                       (rx_pbit != (^rx_sh ^ ~lcfg_reg[`ULM_LC_EVEN])),
                    rx_sh};

   // samples mid-bit; a low stop waits for the line to rise again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st <= ST_IDLE;
         rx_tmr <= 16'h0000;
         rx_sh <= 8'h00;
         rx_bit <= 3'h0;
         rx_zero <= 1'b0;
         rx_pbit <= 1'b0;
      end else begin
         rx_tmr <= (rx_tmr == 16'h0000) ? BITN : rx_tmr - 16'h0001;
         case (rx_st)
            ST_IDLE: if (!rx_in) begin
               rx_tmr <= HALFN;
               rx_st <= ST_START;
            end
            ST_START: if (rx_tmr == 16'h0000) begin
               // a glitch shorter than half a bit is dropped
               rx_st <= rx_in ? ST_IDLE : ST_DATA;
               rx_bit <= 3'h0;
               rx_zero <= 1'b1;
            end
            ST_DATA: if (rx_tmr == 16'h0000) begin
               rx_sh <= {rx_in, rx_sh[7:1]};
               rx_zero <= rx_zero & ~rx_in;
               rx_bit <= rx_bit + 3'h1;
               if (rx_bit == 3'h7)
                  rx_st <= lcfg_reg[`ULM_LC_PEN] ? ST_PAR : ST_STOP;
            end
            ST_PAR: if (rx_tmr == 16'h0000) begin
               rx_pbit <= rx_in;
               rx_zero <= rx_zero & ~rx_in;
               rx_st <= ST_STOP;
            end
            ST_STOP: if (rx_tmr == 16'h0000)
               rx_st <= rx_in ? ST_IDLE : ST_HOLD;
            ST_HOLD: if (rx_in)
               rx_st <= ST_IDLE;
            default: rx_st <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // receive fifo; single-buffer mode is the same store with one slot

   ulm_rx_ent_t rx_mem [DEPTH];
   logic [AW-1:0] rx_wp, rx_rp;
   logic [AW:0] rx_cnt, rx_ecnt;
   logic rx_full, rx_pop, rx_wr, rx_ovw, rx_lost, head_new, head_new_d;
   ulm_rx_ent_t head;

   assign head = rx_mem[rx_rp];
   assign rx_full = (rx_cnt >= cap);
   assign rx_pop = data_rd & (rx_cnt != '0);
   assign rx_wr = rx_done & (~rx_full | rx_pop);
   assign rx_lost = rx_done & rx_full & ~rx_pop;
   assign rx_ovw = rx_lost & ~fen_reg; // single mode overwrites
   assign head_new = (rx_wr & ((rx_cnt == '0) | (rx_pop & rx_cnt == 1)))
                   | rx_ovw | (rx_pop & (rx_cnt > 1));

   // storage; overwrite lands on the unread character
   always_ff @(posedge pclk) begin
      if (rx_wr)
         rx_mem[rx_wp] <= rx_ent;
      else if (rx_ovw)
         rx_mem[rx_rp] <= rx_ent;
   end

   // pointers, count and count of characters carrying errors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_cnt <= '0;
         rx_ecnt <= '0;
      end else if (rx_rst) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_cnt <= '0;
         rx_ecnt <= '0;
      end else begin
         if (rx_wr)
            rx_wp <= rx_wp + 1'b1;
         if (rx_pop)
            rx_rp <= rx_rp + 1'b1;
         rx_cnt <= rx_cnt + {{AW{1'b0}}, rx_wr} - {{AW{1'b0}}, rx_pop};
         rx_ecnt <= rx_ecnt + {{AW{1'b0}}, rx_wr & ent_err(rx_ent)}
                  - {{AW{1'b0}}, rx_pop & ent_err(head)};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // line status flags

   logic [4:1] lerr_reg;   // sil, nstp, perr, ovr
   logic rfe_reg;
   logic [4:1] lerr_set;

   // errors are taken from the head one cycle after it changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         head_new_d <= 1'b0;
      else
         head_new_d <= head_new & ~rx_rst;
   end

   assign lerr_set = {head_new_d ? {head.sil, head.nstp, head.perr}
                                 : 3'b000, rx_lost};

   // read clears only what the read returned, so a late event survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         lerr_reg <= 4'h0;
      else
         lerr_reg <= lerr_set |
            (lerr_reg & ~(st_rd ? prdata[4:1] : 4'h0));
   end

   // fifo error indication, zero in single-buffer mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rfe_reg <= 1'b0;
      else if (!fen_reg || rx_rst)
         rfe_reg <= 1'b0;
      else if (rx_ecnt != '0)
         rfe_reg <= 1'b1;
      else if (st_rd)
         rfe_reg <= 1'b0;
   end

   logic [7:0] lstat;
   assign lstat = {rfe_reg, temt, hold_empty_reg, lerr_reg,
                   rx_cnt != '0};

   ////////////////////////////////////////////////////////////////////
   // read data, captured in the setup phase

   logic [7:0] rmux;
   always_comb begin
      case (paddr)
         `ULM_OFF_DATA: rmux = head.dat;
         `ULM_OFF_IRQEN: rmux = {6'h00, txie_reg, 1'b0};
         `ULM_OFF_FIFO: rmux = {7'h00, fen_reg};
         `ULM_OFF_LINE: rmux = {6'h00, lcfg_reg};
         `ULM_OFF_HCTL: rmux = {3'h0, hctl_reg};
         `ULM_OFF_LSTAT: rmux = lstat;
         `ULM_OFF_HSTAT: rmux = {mstat, 4'h0};
         default: rmux = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable)
         prdata <= {24'h000000, rmux};
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence tx_start_s;
      tx_tick && tx_st == ST_START;
   endsequence
   sequence st_read_s;
      st_rd && !head_new_d && !rx_lost;
   endsequence

   tx_lsb_first_a: assert property (
      tx_start_s |=> tx_line == $past(tx_byte[0]))
      else $error("first data bit is not bit 0");
   rfe_single_a: assert property (!fen_reg |-> !rfe_reg)
      else $error("fifo error flag set in single mode");
   rfe_clear_a: assert property (
      st_rd && fen_reg && rx_ecnt == '0 && !rx_wr && !rx_rst
      |=> !rfe_reg)
      else $error("fifo error flag not cleared by read");
   all_empty_a: assert property (tx_push |=> !temt)
      else $error("all-empty set with data queued");
   holding_clr_a: assert property (
      tx_push && !tx_pop |=> !hold_empty_reg)
      else $error("holding-empty not cleared by write");
   irq_gate_a: assert property (
      irq_out |-> $past(hctl_reg[`ULM_HC_IRQ]) && $past(txie_reg)
         && $past(hold_empty_reg))
      else $error("interrupt without gate or cause");
   err_clear_a: assert property (
      st_read_s |=> (lerr_reg & $past(prdata[4:1])) == 4'h0)
      else $error("status read did not clear error flags");
   ovr_set_a: assert property (rx_lost |=> lerr_reg[1])
      else $error("overrun not flagged");
   ready_a: assert property (
      rx_done && !rx_rst |=> lstat[`ULM_LS_RDY])
      else $error("data ready missing after receive");
   loop_pins_a: assert property (
      loop |-> serial_tx_pin && rts_n && dtr_n)
      else $error("loopback pins not idle");
   cts_loop_a: assert property (
      loop |-> mstat[0] == hctl_reg[`ULM_HC_RTS])
      else $error("cts status not from control bit 1");

endmodule
